// >>> ccsr_pkg.sv
package ccsr_pkg;
    // task register offsets, one word apart from the base
    localparam logic [11:0] CCSR_OFF_TASK_BASE = 12'h000;
    localparam int CCSR_NUM_TASKS = 7;
    localparam int CCSR_TASK_HF_START = 0;
    localparam int CCSR_TASK_HF_STOP = 1;
    localparam int CCSR_TASK_LF_START = 2;
    localparam int CCSR_TASK_LF_STOP = 3;
    localparam int CCSR_TASK_CAL = 4;
    localparam int CCSR_TASK_CT_START = 5;
    localparam int CCSR_TASK_CT_STOP = 6;
    // event registers; index matches the enable bit position
    localparam int CCSR_NUM_EVENTS = 4;
    localparam int CCSR_EVT_HF_STARTED = 0;
    localparam int CCSR_EVT_LF_STARTED = 1;
    localparam int CCSR_EVT_CAL_DONE = 2;
    localparam int CCSR_EVT_CT_TIMEOUT = 3;
    localparam logic [3:0][11:0] CCSR_OFF_EVENT = {12'h110, 12'h10c, 12'h104, 12'h100};
    localparam logic [11:0] CCSR_OFF_INT_ENABLE_SET = 12'h304;
    localparam logic [11:0] CCSR_OFF_INT_ENABLE_CLEAR = 12'h308;
    localparam logic [11:0] CCSR_OFF_HF_START_REQUESTED = 12'h408;
    localparam logic [11:0] CCSR_OFF_HF_CLOCK_STATUS = 12'h40c;
    localparam logic [11:0] CCSR_OFF_LF_START_REQUESTED = 12'h414;
    localparam logic [11:0] CCSR_OFF_LF_CLOCK_STATUS = 12'h418;
    localparam logic [11:0] CCSR_OFF_LF_SOURCE_SNAPSHOT = 12'h41c;
    localparam logic [11:0] CCSR_OFF_LF_SOURCE_SELECT = 12'h518;
    localparam logic [11:0] CCSR_OFF_CAL_TIMER_INTERVAL = 12'h538;
    // field positions
    localparam int CCSR_STATE_BIT = 16;
    localparam int CCSR_BYPASS_BIT = 16;
    localparam int CCSR_EXTERNAL_BIT = 17;
    localparam int CCSR_CAL_TIMER_INTERVAL_WIDTH = 7;
    // source codes
    localparam logic [1:0] CCSR_LF_SRC_RC = 2'h0;
    localparam logic [1:0] CCSR_LF_SRC_XTAL = 2'h1;
    localparam logic [1:0] CCSR_LF_SRC_SYNTH = 2'h2;
    // reset values
    localparam logic [31:0] CCSR_RESET_WORD = 32'h0000_0000;
    localparam logic [1:0] CCSR_RESET_LF_SRC = 2'h0;
    localparam logic [6:0] CCSR_RESET_CAL_TIMER_INTERVAL = 7'h00;
    // address window and identifier derivation
    localparam logic [31:0] CCSR_PERIPH_REGION = 32'h4000_0000;
    localparam logic [31:0] CCSR_BASE_ADDR = 32'h4000_0000;
    localparam logic [31:0] CCSR_WINDOW_BYTES = 32'h0000_1000;
    localparam int CCSR_ID_WIDTH = 5;
endpackage

// >>> ccsr_evt_if.sv
`timescale 1ns/1ps
interface ccsr_evt_if;
    logic [3:0] evt_pulse;
    logic [3:0] evt_clr;
    logic en_set_wr;
    logic en_clr_wr;
    logic [3:0] wdata;
    logic [3:0] evt_flags;
    logic [3:0] int_enable;
    logic irq;
    modport ctrl (
        output evt_pulse, evt_clr, en_set_wr, en_clr_wr, wdata,
        input evt_flags, int_enable, irq
    );
    modport unit (
        input evt_pulse, evt_clr, en_set_wr, en_clr_wr, wdata,
        output evt_flags, int_enable, irq
    );
endinterface

// >>> ccsr_event_unit.sv
`timescale 1ns/1ps
module ccsr_event_unit
    import ccsr_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    ccsr_evt_if.unit evt
);
    logic [3:0] flags;
    logic [3:0] enable;

    // a new event in the clearing cycle keeps the flag set
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            flags <= CCSR_RESET_WORD[3:0];
        end else begin
            flags <= evt.evt_pulse | (flags & ~evt.evt_clr);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            enable <= CCSR_RESET_WORD[3:0];
        end else if (evt.en_set_wr) begin
            enable <= enable | evt.wdata;
        end else if (evt.en_clr_wr) begin
            enable <= enable & ~evt.wdata;
        end
    end

    assign evt.evt_flags = flags;
    assign evt.int_enable = enable;
    assign evt.irq = |(flags & enable);

    property p_set_wins;
        @(posedge clock) disable iff (!rst_b)
        (evt.evt_pulse != 4'h0) |=> ((flags & $past(evt.evt_pulse)) == $past(evt.evt_pulse));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost");

    property p_flag_holds;
        @(posedge clock) disable iff (!rst_b)
        (evt.evt_clr == 4'h0) |=> ((flags & $past(flags)) == $past(flags));
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("flag dropped without clear");

    property p_en_set;
        @(posedge clock) disable iff (!rst_b)
        evt.en_set_wr |=> ((enable & $past(evt.wdata)) == $past(evt.wdata));
    endproperty
    a_en_set: assert property (p_en_set) else $error("enable set failed");

    property p_en_clr;
        @(posedge clock) disable iff (!rst_b)
        (evt.en_clr_wr && !evt.en_set_wr) |=> ((enable & $past(evt.wdata)) == 4'h0);
    endproperty
    a_en_clr: assert property (p_en_clr) else $error("enable clear failed");

    property p_irq;
        @(posedge clock) disable iff (!rst_b)
        ((flags & enable) != 4'h0) |-> evt.irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    c_irq_raise: cover property (@(posedge clock) disable iff (!rst_b) $rose(evt.irq));
endmodule

// >>> ccsr_top.sv
`timescale 1ns/1ps
module ccsr_top
    import ccsr_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic retain_rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [6:0] task_in,
    output logic [6:0] task_out,
    input wire logic [3:0] event_in,
    input wire logic hf_src_xtal,
    input wire logic hf_running,
    input wire logic [1:0] lf_src_active,
    input wire logic lf_running,
    output logic [1:0] lf_source_field,
    output logic lf_bypass,
    output logic lf_external,
    output logic [6:0] cal_interval,
    output logic [4:0] periph_id,
    output logic irq
);
    ccsr_evt_if evt ();

    logic [11:0] offs;
    logic access_wr;
    logic setup;
    logic [6:0] sw_task;
    logic [6:0] trig;
    logic hf_req;
    logic lf_req;
    logic [1:0] lf_snapshot;
    logic [31:0] next_rdata;
    logic next_err;

    function automatic logic is_mapped(input logic [11:0] a);
        logic m;
        m = 1'b0;
        for (int i = 0; i < CCSR_NUM_TASKS; i++) begin
            if (a == CCSR_OFF_TASK_BASE + 12'(4 * i)) begin
                m = 1'b1;
            end
        end
        for (int i = 0; i < CCSR_NUM_EVENTS; i++) begin
            if (a == CCSR_OFF_EVENT[i]) begin
                m = 1'b1;
            end
        end
        case (a)
            CCSR_OFF_INT_ENABLE_SET, CCSR_OFF_INT_ENABLE_CLEAR,
            CCSR_OFF_HF_START_REQUESTED, CCSR_OFF_HF_CLOCK_STATUS,
            CCSR_OFF_LF_START_REQUESTED, CCSR_OFF_LF_CLOCK_STATUS,
            CCSR_OFF_LF_SOURCE_SNAPSHOT, CCSR_OFF_LF_SOURCE_SELECT,
            CCSR_OFF_CAL_TIMER_INTERVAL: m = 1'b1;
            default: m = m;
        endcase
        return m;
    endfunction

    function automatic logic [4:0] id_of(input logic [31:0] base);
        logic [31:0] step;
        step = (base - CCSR_PERIPH_REGION) / CCSR_WINDOW_BYTES;
        return step[CCSR_ID_WIDTH-1:0];
    endfunction

    // only the low bits select a register; upper bits are the window
    assign offs = {paddr[11:2], 2'b00};
    assign setup = psel & ~penable;
    assign access_wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign periph_id = id_of(CCSR_BASE_ADDR);

    always_comb begin
        for (int i = 0; i < CCSR_NUM_TASKS; i++) begin
            sw_task[i] = access_wr && pwdata[0]
                && (offs == CCSR_OFF_TASK_BASE + 12'(4 * i));
        end
    end
    assign trig = sw_task | task_in;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            task_out <= CCSR_RESET_WORD[6:0];
        end else begin
            task_out <= trig;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            hf_req <= 1'b0;
        end else if (trig[CCSR_TASK_HF_START]) begin
            hf_req <= 1'b1;
        end else if (trig[CCSR_TASK_HF_STOP]) begin
            hf_req <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            lf_req <= 1'b0;
        end else if (trig[CCSR_TASK_LF_START]) begin
            lf_req <= 1'b1;
        end else if (trig[CCSR_TASK_LF_STOP]) begin
            lf_req <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            lf_snapshot <= CCSR_RESET_LF_SRC;
        end else if (trig[CCSR_TASK_LF_START]) begin
            lf_snapshot <= lf_source_field;
        end
    end

    // writes are dropped while the low-frequency clock runs
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            lf_source_field <= CCSR_RESET_LF_SRC;
            lf_bypass <= 1'b0;
            lf_external <= 1'b0;
        end else if (access_wr && offs == CCSR_OFF_LF_SOURCE_SELECT && !lf_running) begin
            lf_source_field <= pwdata[1:0];
            lf_bypass <= pwdata[CCSR_BYPASS_BIT];
            lf_external <= pwdata[CCSR_EXTERNAL_BIT];
        end
    end

    // retention domain: ordinary reset leaves the interval alone
    always_ff @(posedge clock) begin
        if (!retain_rst_b) begin
            cal_interval <= CCSR_RESET_CAL_TIMER_INTERVAL;
        end else if (access_wr && offs == CCSR_OFF_CAL_TIMER_INTERVAL) begin
            cal_interval <= pwdata[CCSR_CAL_TIMER_INTERVAL_WIDTH-1:0];
        end
    end

    assign evt.evt_pulse = event_in;
    assign evt.en_set_wr = access_wr && offs == CCSR_OFF_INT_ENABLE_SET;
    assign evt.en_clr_wr = access_wr && offs == CCSR_OFF_INT_ENABLE_CLEAR;
    assign evt.wdata = pwdata[3:0];
    always_comb begin
        for (int i = 0; i < CCSR_NUM_EVENTS; i++) begin
            evt.evt_clr[i] = access_wr && !pwdata[0] && offs == CCSR_OFF_EVENT[i];
        end
    end
    assign irq = evt.irq;

    ccsr_event_unit u_events (
        .clock(clock),
        .rst_b(rst_b),
        .evt(evt)
    );

    always_comb begin
        next_rdata = CCSR_RESET_WORD;
        for (int i = 0; i < CCSR_NUM_EVENTS; i++) begin
            if (offs == CCSR_OFF_EVENT[i]) begin
                next_rdata[0] = evt.evt_flags[i];
            end
        end
        case (offs)
            CCSR_OFF_INT_ENABLE_SET, CCSR_OFF_INT_ENABLE_CLEAR: begin
                next_rdata[3:0] = evt.int_enable;
            end
            CCSR_OFF_HF_START_REQUESTED: begin
                next_rdata[0] = hf_req;
            end
            CCSR_OFF_HF_CLOCK_STATUS: begin
                next_rdata[0] = hf_src_xtal;
                next_rdata[CCSR_STATE_BIT] = hf_running;
            end
            CCSR_OFF_LF_START_REQUESTED: begin
                next_rdata[0] = lf_req;
            end
            CCSR_OFF_LF_CLOCK_STATUS: begin
                next_rdata[1:0] = lf_src_active;
                next_rdata[CCSR_STATE_BIT] = lf_running;
            end
            CCSR_OFF_LF_SOURCE_SNAPSHOT: begin
                next_rdata[1:0] = lf_snapshot;
            end
            CCSR_OFF_LF_SOURCE_SELECT: begin
                next_rdata[1:0] = lf_source_field;
                next_rdata[CCSR_BYPASS_BIT] = lf_bypass;
                next_rdata[CCSR_EXTERNAL_BIT] = lf_external;
            end
            CCSR_OFF_CAL_TIMER_INTERVAL: begin
                next_rdata[CCSR_CAL_TIMER_INTERVAL_WIDTH-1:0] = cal_interval;
            end
            default: begin
                next_rdata = next_rdata;
            end
        endcase
        next_err = !is_mapped(offs);
    end

    // read data is sampled in the setup cycle, so the single access cycle can answer at once
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            prdata <= CCSR_RESET_WORD;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? CCSR_RESET_WORD : next_rdata;
            pslverr <= next_err;
        end
    end

    property p_hf_req;
        @(posedge clock) disable iff (!rst_b)
        trig[CCSR_TASK_HF_START] |=> hf_req;
    endproperty
    a_hf_req: assert property (p_hf_req) else $error("hf request not set");

    property p_lf_req;
        @(posedge clock) disable iff (!rst_b)
        (!lf_req && !trig[CCSR_TASK_LF_START]) |=> !lf_req;
    endproperty
    a_lf_req: assert property (p_lf_req) else $error("lf request set without task");

    property p_snapshot;
        @(posedge clock) disable iff (!rst_b)
        trig[CCSR_TASK_LF_START] |=> (lf_snapshot == $past(lf_source_field));
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("snapshot wrong");

    property p_src_locked;
        @(posedge clock) disable iff (!rst_b)
        lf_running |=> $stable(lf_source_field);
    endproperty
    a_src_locked: assert property (p_src_locked) else $error("source changed while running");

    property p_src_write;
        @(posedge clock) disable iff (!rst_b)
        (access_wr && offs == CCSR_OFF_LF_SOURCE_SELECT && !lf_running)
            |=> (lf_source_field == $past(pwdata[1:0])
                && lf_external == $past(pwdata[CCSR_EXTERNAL_BIT])
                && lf_bypass == $past(pwdata[CCSR_BYPASS_BIT]));
    endproperty
    a_src_write: assert property (p_src_write) else $error("source write lost");

    property p_retained;
        @(posedge clock) disable iff (!retain_rst_b)
        !rst_b |=> $stable(cal_interval);
    endproperty
    a_retained: assert property (p_retained) else $error("interval lost in reset");

    property p_task_out;
        @(posedge clock) disable iff (!rst_b)
        task_in[CCSR_TASK_CAL] |=> task_out[CCSR_TASK_CAL];
    endproperty
    a_task_out: assert property (p_task_out) else $error("task input not forwarded");

    property p_unmapped;
        @(posedge clock) disable iff (!rst_b)
        (setup && !is_mapped(offs)) |=> (pslverr && prdata == 32'h0000_0000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access answered");

    property p_irq_top;
        @(posedge clock) disable iff (!rst_b)
        (event_in[CCSR_EVT_CT_TIMEOUT] && evt.int_enable[CCSR_EVT_CT_TIMEOUT] && !evt.en_clr_wr)
            |=> irq;
    endproperty
    a_irq_top: assert property (p_irq_top) else $error("enabled event gave no irq");

    property p_hf_stop;
        @(posedge clock) disable iff (!rst_b)
        (trig[CCSR_TASK_HF_STOP] && !trig[CCSR_TASK_HF_START]) |=> !hf_req;
    endproperty
    a_hf_stop: assert property (p_hf_stop) else $error("hf request not cleared");

    property p_lf_req_set;
        @(posedge clock) disable iff (!rst_b)
        trig[CCSR_TASK_LF_START] |=> lf_req;
    endproperty
    a_lf_req_set: assert property (p_lf_req_set) else $error("lf request not set");

    property p_sw_task;
        @(posedge clock) disable iff (!rst_b)
        (access_wr && pwdata[0] && offs == CCSR_OFF_TASK_BASE + 12'(4 * CCSR_TASK_CT_STOP))
            |=> task_out[CCSR_TASK_CT_STOP];
    endproperty
    a_sw_task: assert property (p_sw_task) else $error("task write not fired");

    property p_mapped_ok;
        @(posedge clock) disable iff (!rst_b)
        (setup && is_mapped(offs)) |=> !pslverr;
    endproperty
    a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access flagged");

    property p_wr_rdata;
        @(posedge clock) disable iff (!rst_b)
        (setup && pwrite) |=> (prdata == CCSR_RESET_WORD);
    endproperty
    a_wr_rdata: assert property (p_wr_rdata) else $error("read data on a write");

    property p_cal_timer_interval_write;
        @(posedge clock) disable iff (!retain_rst_b)
        (access_wr && offs == CCSR_OFF_CAL_TIMER_INTERVAL)
            |=> (cal_interval == $past(pwdata[CCSR_CAL_TIMER_INTERVAL_WIDTH-1:0]));
    endproperty
    a_cal_timer_interval_write: assert property (p_cal_timer_interval_write) else $error("interval write lost");

    property p_hf_stat_read;
        @(posedge clock) disable iff (!rst_b)
        (setup && !pwrite && offs == CCSR_OFF_HF_CLOCK_STATUS)
            |=> (prdata[0] == $past(hf_src_xtal) && prdata[CCSR_STATE_BIT] == $past(hf_running));
    endproperty
    a_hf_stat_read: assert property (p_hf_stat_read) else $error("hf status wrong");

    property p_lf_stat_read;
        @(posedge clock) disable iff (!rst_b)
        (setup && !pwrite && offs == CCSR_OFF_LF_CLOCK_STATUS)
            |=> (prdata[1:0] == $past(lf_src_active) && prdata[CCSR_STATE_BIT] == $past(lf_running));
    endproperty
    a_lf_stat_read: assert property (p_lf_stat_read) else $error("lf status wrong");

    c_lf_start: cover property (@(posedge clock) disable iff (!rst_b)
        trig[CCSR_TASK_LF_START] ##1 lf_req);
    c_evt_clear: cover property (@(posedge clock) disable iff (!rst_b)
        evt.evt_clr != 4'h0);
    c_cal_timer_interval_write: cover property (@(posedge clock) disable iff (!rst_b)
        access_wr && offs == CCSR_OFF_CAL_TIMER_INTERVAL);
endmodule

// >>> ccsr_top_test.sv
`timescale 1ns/1ps
module ccsr_top_test
    import ccsr_pkg::*;
;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic retain_rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [6:0] task_in = 7'h0;
    logic [3:0] event_in = 4'h0;
    logic hf_src_xtal = 1'b0;
    logic hf_running = 1'b0;
    logic [1:0] lf_src_active = 2'h0;
    logic lf_running = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [6:0] task_out;
    logic [1:0] lf_source_field;
    logic lf_bypass;
    logic lf_external;
    logic [6:0] cal_interval;
    logic [4:0] periph_id;
    logic irq;
    int fails = 0;
    int n_compared = 0;
    int k;
    logic [31:0] seed = 32'd32016;
    logic [31:0] r;
    logic [31:0] e;
    logic [31:0] rdata;
    logic rerr;
    logic [3:0] en;
    logic [1:0] s;
    localparam logic [11:0] rst_regs [9] = '{CCSR_OFF_INT_ENABLE_SET,
        CCSR_OFF_INT_ENABLE_CLEAR, CCSR_OFF_HF_START_REQUESTED, CCSR_OFF_HF_CLOCK_STATUS,
        CCSR_OFF_LF_START_REQUESTED, CCSR_OFF_LF_CLOCK_STATUS, CCSR_OFF_LF_SOURCE_SNAPSHOT,
        CCSR_OFF_LF_SOURCE_SELECT, CCSR_OFF_CAL_TIMER_INTERVAL};

    ccsr_top u_ccsr_top (.clock(clock), .rst_b(rst_b), .retain_rst_b(retain_rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .task_in(task_in),
        .task_out(task_out), .event_in(event_in), .hf_src_xtal(hf_src_xtal),
        .hf_running(hf_running), .lf_src_active(lf_src_active), .lf_running(lf_running),
        .lf_source_field(lf_source_field), .lf_bypass(lf_bypass), .lf_external(lf_external),
        .cal_interval(cal_interval), .periph_id(periph_id), .irq(irq));

    always #2.5 clock = ~clock;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] ra(input logic [11:0] o);
        return CCSR_BASE_ADDR | {20'h0, o};
    endfunction

    // status word: running flag in the state bit, source code at the bottom
    function automatic logic [31:0] stat(input logic run, input logic [1:0] src);
        return (32'(run) << CCSR_STATE_BIT) | {30'h0, src};
    endfunction

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask

    // no wait-state count assumed; the loop bound only guards a hang
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            fails++;
            wrap_up();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] o, input logic [31:0] d);
        apb(1'b1, ra(o), d);
    endtask

    task automatic rd(input logic [11:0] o, input logic [31:0] exp);
        apb(1'b0, ra(o), 32'h0);
        chk(rdata, exp);
        chk({31'h0, rerr}, 32'h0);
    endtask

    task automatic pulse_evt(input int i);
        @(posedge clock);
        event_in <= 4'(1 << i);
        @(posedge clock);
        event_in <= 4'h0;
        #1;
    endtask

    initial begin
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        retain_rst_b <= 1'b1;
        for (k = 0; k < 9; k++) rd(rst_regs[k], CCSR_RESET_WORD);
        chk({27'h0, periph_id}, 32'h0);
        en = 4'h0;
        for (k = 0; k < 12; k++) begin
            r = (k == 11) ? 32'h0 : rnd();
            wr(CCSR_OFF_INT_ENABLE_SET, r);
            en = en | r[3:0];
            rd(CCSR_OFF_INT_ENABLE_SET, {28'h0, en});
            r = (k == 10) ? 32'h0 : rnd();
            wr(CCSR_OFF_INT_ENABLE_CLEAR, r);
            en = en & ~r[3:0];
            rd(CCSR_OFF_INT_ENABLE_CLEAR, {28'h0, en});
        end
        wr(CCSR_OFF_INT_ENABLE_SET, 32'hffff_ffff);
        rd(CCSR_OFF_INT_ENABLE_CLEAR, 32'h0000_000f);
        wr(CCSR_OFF_INT_ENABLE_CLEAR, 32'h0000_000f);
        for (k = 0; k < CCSR_NUM_EVENTS; k++) begin
            pulse_evt(k);
            chk({31'h0, irq}, 32'h0);
            wr(CCSR_OFF_EVENT[k], 32'h1);
            rd(CCSR_OFF_EVENT[k], 32'h1);
            wr(CCSR_OFF_INT_ENABLE_SET, 32'(1 << k));
            #1;
            chk({31'h0, irq}, 32'h1);
            wr(CCSR_OFF_EVENT[k], 32'h0);
            #1;
            chk({31'h0, irq}, 32'h0);
            rd(CCSR_OFF_EVENT[k], 32'h0);
            wr(CCSR_OFF_INT_ENABLE_CLEAR, 32'h0000_000f);
        end
        for (k = 0; k < CCSR_NUM_TASKS; k++) begin
            @(posedge clock);
            task_in <= 7'(1 << k);
            @(posedge clock);
            task_in <= 7'h0;
            #1;
            chk({25'h0, task_out}, 32'(1 << k));
            @(posedge clock);
            #1;
            chk({25'h0, task_out}, 32'h0);
        end
        for (k = 0; k < CCSR_NUM_TASKS; k++) begin
            wr(CCSR_OFF_TASK_BASE + 12'(4 * k), 32'h0);
            #1;
            chk({25'h0, task_out}, 32'h0);
            wr(CCSR_OFF_TASK_BASE + 12'(4 * k), 32'h1);
            #1;
            chk({25'h0, task_out}, 32'(1 << k));
        end
        wr(CCSR_OFF_TASK_BASE + 12'(4 * CCSR_TASK_HF_START), 32'h1);
        rd(CCSR_OFF_HF_START_REQUESTED, 32'h1);
        wr(CCSR_OFF_TASK_BASE + 12'(4 * CCSR_TASK_HF_STOP), 32'h1);
        rd(CCSR_OFF_HF_START_REQUESTED, 32'h0);
        wr(CCSR_OFF_LF_SOURCE_SELECT, {30'h0, CCSR_LF_SRC_XTAL});
        wr(CCSR_OFF_TASK_BASE + 12'(4 * CCSR_TASK_LF_START), 32'h1);
        rd(CCSR_OFF_LF_START_REQUESTED, 32'h1);
        wr(CCSR_OFF_LF_SOURCE_SELECT, {30'h0, CCSR_LF_SRC_SYNTH});
        rd(CCSR_OFF_LF_SOURCE_SNAPSHOT, {30'h0, CCSR_LF_SRC_XTAL});
        wr(CCSR_OFF_TASK_BASE + 12'(4 * CCSR_TASK_LF_STOP), 32'h1);
        rd(CCSR_OFF_LF_START_REQUESTED, 32'h0);
        for (k = 0; k < 8; k++) begin
            r = rnd();
            s = (r[3:2] == 2'h3) ? CCSR_LF_SRC_SYNTH : r[3:2];
            hf_src_xtal <= r[0];
            hf_running <= r[1];
            lf_src_active <= s;
            lf_running <= r[4];
            rd(CCSR_OFF_HF_CLOCK_STATUS, stat(r[1], {1'b0, r[0]}));
            rd(CCSR_OFF_LF_CLOCK_STATUS, stat(r[4], s));
        end
        lf_running <= 1'b0;
        for (k = 0; k < 8; k++) begin
            r = rnd();
            // external clock only with the crystal code selected
            s = r[17] ? CCSR_LF_SRC_XTAL : ((r[1:0] == 2'h3) ? CCSR_LF_SRC_RC : r[1:0]);
            e = {14'h0, r[17:16], 14'h0, s};
            wr(CCSR_OFF_LF_SOURCE_SELECT, {r[31:2], s});
            rd(CCSR_OFF_LF_SOURCE_SELECT, e);
            chk({28'h0, lf_external, lf_bypass, lf_source_field}, {28'h0, r[17:16], s});
        end
        // selector is frozen while the low-frequency clock runs
        lf_running <= 1'b1;
        wr(CCSR_OFF_LF_SOURCE_SELECT, ~e);
        rd(CCSR_OFF_LF_SOURCE_SELECT, e);
        lf_running <= 1'b0;
        for (k = 0; k < 3; k++) begin
            r = (k == 0) ? rnd() : ((k == 1) ? 32'h0000_007f : 32'hffff_ff80);
            wr(CCSR_OFF_CAL_TIMER_INTERVAL, r);
            rd(CCSR_OFF_CAL_TIMER_INTERVAL, r & 32'h0000_007f);
            chk({25'h0, cal_interval}, r & 32'h0000_007f);
        end
        wr(CCSR_OFF_CAL_TIMER_INTERVAL, 32'h0000_0055);
        @(posedge clock);
        rst_b <= 1'b0;
        @(posedge clock);
        rst_b <= 1'b1;
        rd(CCSR_OFF_CAL_TIMER_INTERVAL, 32'h0000_0055);
        rd(CCSR_OFF_LF_SOURCE_SELECT, 32'h0);
        @(posedge clock);
        retain_rst_b <= 1'b0;
        @(posedge clock);
        retain_rst_b <= 1'b1;
        rd(CCSR_OFF_CAL_TIMER_INTERVAL, 32'h0);
        wr(CCSR_OFF_CAL_TIMER_INTERVAL, 32'h0000_0015);
        // upper address bits ignored: a far alias lands on the same word
        apb(1'b0, 32'h4001_f538, 32'h0);
        chk(rdata, 32'h0000_0015);
        apb(1'b1, ra(12'h500), 32'hffff_ffff);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b0, ra(12'h500), 32'h0);
        chk(rdata, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        wrap_up();
    end
endmodule
